// file: shared/psm_consts.svh
// offsets, field positions, reset values and timing counts of the power-saving control block
`ifndef PSM_CONSTS_SVH
`define PSM_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define PSM_ADDR_W 4
`define PSM_DATA_W 16
`define PSM_OFF_OSC_CTL 4'h0
`define PSM_OFF_RST_CTL 4'h1
`define PSM_OFF_CLK_DIV 4'h2
`define PSM_OFF_MOD_DIS 4'h3
`define PSM_OFF_STOP_IDLE 4'h4
`define PSM_OFF_STATUS 4'h5

// ****************************************
// field positions
// ****************************************
`define PSM_NOSC_HI 10
`define PSM_NOSC_LO 8
`define PSM_REG_STBY_BIT 8
`define PSM_LP_REG_BIT 9
`define PSM_DOZE_EN_BIT 11
`define PSM_RATIO_HI 14
`define PSM_RATIO_LO 12
`define PSM_ROI_BIT 15
`define PSM_ST_SLEEP_BIT 0
`define PSM_ST_IDLE_BIT 1
`define PSM_ST_DOZE_BIT 2
`define PSM_ST_OSC_LO 3
`define PSM_ST_MODE_LO 6

// ****************************************
// reset values and timing counts
// ****************************************
`define PSM_OSC_RST 3'h0
`define PSM_RATIO_RST 3'h0
`define PSM_NUM_PERIPH 16
`define PSM_RESUME_CYC 2'h3
`define PSM_ROI_TICKS 2'h2

`endif

// file: shared/psm_pkg.sv
// types shared by the power-saving control block
package psm_pkg;

  // ****************************************
  // controller states
  // ****************************************
  typedef enum logic [2:0] {
    st_run,
    st_enter,
    st_sleep,
    st_idle,
    st_wake
  } psm_state_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic irq;
    logic wdt_timeout;
  } psm_wake_t;

  typedef struct packed {
    logic wdt_en;
    logic fail_safe_clock_monitor_en;
    logic cfg_locked;
  } psm_cfg_t;

  typedef struct packed {
    logic sysclk_on;
    logic low_rate_rc_oscillator_on;
    logic fail_safe_clock_monitor_run;
    logic reg_standby;
    logic lp_regulator;
  } psm_pwr_t;

endpackage

// file: logic/psm_power_saving_mode_control.sv
// power-saving mode controller: sleep, idle, cpu slowdown and module disable gating
`include "psm_consts.svh"
module psm_power_saving_mode_control #(
  parameter int NUM_PERIPH = `PSM_NUM_PERIPH,
  parameter logic [NUM_PERIPH-1:0] PERIPH_PRESENT = '1
) (
  // clock and reset
  input logic core_clk,
  input logic sys_rst,
  // register port
  input logic [`PSM_ADDR_W-1:0] reg_addr,
  input logic [`PSM_DATA_W-1:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [`PSM_DATA_W-1:0] reg_rdata,
  // cpu core and wake sources
  input logic power_save_instruction_exec,
  input logic power_save_instruction_sleep,
  input psm_pkg::psm_wake_t wake_in,
  input psm_pkg::psm_cfg_t cfg_in,
  // cpu clocking
  output logic cpu_clk_en,
  output logic cpu_resume,
  output logic resume_isr,
  output logic wdt_clear,
  // clock sources and regulators
  output psm_pkg::psm_pwr_t pwr_out,
  output logic [2:0] active_osc,
  // peripheral enables
  output logic [NUM_PERIPH-1:0] periph_on
);
  // ****************************************
  // declarations
  // ****************************************
  psm_pkg::psm_state_t state_reg;
  logic mode_sleep_reg, irq_held_reg, roi_pend_reg;
  logic [1:0] resume_cnt_reg, roi_ticks_reg, sleep_mode_code;
  logic [2:0] new_oscillator_select_reg, doze_ratio_reg, active_osc_reg;
  logic regulator_standby_control_reg, low_power_regulator_enable_reg, cpu_slowdown_enable_reg;
  logic return_on_interrupt_reg, cpu_clk_en_reg, cpu_resume_reg, resume_isr_reg, wdt_clear_reg;
  logic [NUM_PERIPH-1:0] module_disable_reg, module_disable_eff_reg, stop_in_idle_bit_reg, periph_on_reg;
  logic [6:0] doze_cnt_reg, doze_mask;
  psm_pkg::psm_pwr_t pwr_reg;
  logic [`PSM_DATA_W-1:0] rdata_reg, rd_mux;
  logic wr_osc, wr_rst, wr_div, wr_dis, wr_stop_in_idle_bit;
  logic wake_any, entering, doze_tick, roi_done;
  // ratio code n means divide by 2**n
  function automatic logic [6:0] ratio_mask(input logic [2:0] code);
    logic [7:0] one_hot;
    one_hot = 8'h01 << code;
    return 7'(one_hot - 8'h01);
  endfunction
  // ****************************************
  // decode
  // ****************************************
  assign wr_osc = reg_wr && (reg_addr == `PSM_OFF_OSC_CTL);
  assign wr_rst = reg_wr && (reg_addr == `PSM_OFF_RST_CTL);
  assign wr_div = reg_wr && (reg_addr == `PSM_OFF_CLK_DIV);
  assign wr_dis = reg_wr && (reg_addr == `PSM_OFF_MOD_DIS);
  assign wr_stop_in_idle_bit = reg_wr && (reg_addr == `PSM_OFF_STOP_IDLE);
  assign entering = (state_reg == psm_pkg::st_run) && power_save_instruction_exec;
  assign wake_any = wake_in.irq || wake_in.wdt_timeout || irq_held_reg;
  assign doze_mask = ratio_mask(doze_ratio_reg);
  assign doze_tick = (doze_cnt_reg >= doze_mask); // a lowered ratio never waits for a counter wrap
  assign roi_done = roi_pend_reg && doze_tick && (roi_ticks_reg == `PSM_ROI_TICKS - 2'h1);
  assign sleep_mode_code = {low_power_regulator_enable_reg, ~regulator_standby_control_reg};
  // ****************************************
  // mode sequencer
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= psm_pkg::st_run;
      mode_sleep_reg <= 1'b0;
    end else begin
      case (state_reg)
        psm_pkg::st_run: begin
          if (power_save_instruction_exec) begin
            state_reg <= psm_pkg::st_enter;
            mode_sleep_reg <= power_save_instruction_sleep;
          end
        end
        psm_pkg::st_enter: state_reg <= mode_sleep_reg ? psm_pkg::st_sleep : psm_pkg::st_idle;
        psm_pkg::st_sleep, psm_pkg::st_idle: begin
          if (wake_any) begin
            state_reg <= psm_pkg::st_wake;
          end
        end
        psm_pkg::st_wake: begin
          if (resume_cnt_reg == `PSM_RESUME_CYC - 2'h1) begin
            state_reg <= psm_pkg::st_run;
          end
        end
        default: state_reg <= psm_pkg::st_run;
      endcase
    end
  end
  // interrupt during entry is kept until the wake state is reached
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_held_reg <= 1'b0;
    end else if (state_reg == psm_pkg::st_enter && wake_in.irq) begin
      irq_held_reg <= 1'b1;
    end else if (state_reg == psm_pkg::st_wake) begin
      irq_held_reg <= 1'b0;
    end
  end
  // ****************************************
  // wake-up and resume
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      resume_cnt_reg <= 2'h0;
      cpu_resume_reg <= 1'b0;
      resume_isr_reg <= 1'b0;
    end else begin
      cpu_resume_reg <= 1'b0;
      if (state_reg == psm_pkg::st_wake) begin
        resume_cnt_reg <= resume_cnt_reg + 2'h1;
        if (resume_cnt_reg == `PSM_RESUME_CYC - 2'h1) begin
          cpu_resume_reg <= 1'b1;
        end
      end else begin
        resume_cnt_reg <= 2'h0;
      end
      if ((state_reg == psm_pkg::st_sleep || state_reg == psm_pkg::st_idle) && wake_any) begin
        resume_isr_reg <= wake_in.irq || irq_held_reg;
      end
    end
  end

  // watchdog count cleared in the cycle before the low-power state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wdt_clear_reg <= 1'b0;
    end else begin
      wdt_clear_reg <= entering && cfg_in.wdt_en;
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      new_oscillator_select_reg <= `PSM_OSC_RST;
    end else if (wr_osc && !cfg_in.cfg_locked) begin
      new_oscillator_select_reg <= reg_wdata[`PSM_NOSC_HI:`PSM_NOSC_LO];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      regulator_standby_control_reg <= 1'b0;
      low_power_regulator_enable_reg <= 1'b0;
    end else if (wr_rst) begin
      regulator_standby_control_reg <= reg_wdata[`PSM_REG_STBY_BIT];
      low_power_regulator_enable_reg <= reg_wdata[`PSM_LP_REG_BIT];
    end
  end

  // hardware return-on-interrupt clear loses to a same-cycle software write
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cpu_slowdown_enable_reg <= 1'b0;
      return_on_interrupt_reg <= 1'b0;
      doze_ratio_reg <= `PSM_RATIO_RST;
    end else if (wr_div) begin
      cpu_slowdown_enable_reg <= reg_wdata[`PSM_DOZE_EN_BIT];
      return_on_interrupt_reg <= reg_wdata[`PSM_ROI_BIT];
      doze_ratio_reg <= reg_wdata[`PSM_RATIO_HI:`PSM_RATIO_LO];
    end else if (roi_done) begin
      cpu_slowdown_enable_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      module_disable_reg <= '0;
      stop_in_idle_bit_reg <= '0;
    end else begin
      if (wr_dis) begin
        module_disable_reg <= reg_wdata[NUM_PERIPH-1:0];
      end
      if (wr_stop_in_idle_bit) begin
        stop_in_idle_bit_reg <= reg_wdata[NUM_PERIPH-1:0];
      end
    end
  end

  // ****************************************
  // cpu slowdown divider
  // ****************************************
  // divider runs from the system clock so peripherals never see the slowdown
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      doze_cnt_reg <= 7'h00;
    end else if (doze_tick) begin
      doze_cnt_reg <= 7'h00;
    end else begin
      doze_cnt_reg <= doze_cnt_reg + 7'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      roi_pend_reg <= 1'b0;
      roi_ticks_reg <= 2'h0;
    end else if (!cpu_slowdown_enable_reg || roi_done) begin
      roi_pend_reg <= 1'b0;
      roi_ticks_reg <= 2'h0;
    end else if (!roi_pend_reg) begin
      roi_pend_reg <= return_on_interrupt_reg && wake_in.irq;
    end else if (doze_tick) begin
      roi_ticks_reg <= roi_ticks_reg + 2'h1;
    end
  end

  // cpu clock enable: every cycle at full speed, one per divided period otherwise
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cpu_clk_en_reg <= 1'b0;
    end else begin
      cpu_clk_en_reg <= (state_reg == psm_pkg::st_run) && !entering &&
                        (!cpu_slowdown_enable_reg || doze_tick);
    end
  end

  // ****************************************
  // clock sources and regulators
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pwr_reg <= '0;
    end else begin
      pwr_reg.sysclk_on <= (state_reg != psm_pkg::st_sleep);
      pwr_reg.fail_safe_clock_monitor_run <= cfg_in.fail_safe_clock_monitor_en && (state_reg != psm_pkg::st_sleep);
      if (state_reg == psm_pkg::st_sleep) begin
        pwr_reg.low_rate_rc_oscillator_on <= cfg_in.wdt_en;
      end else begin
        pwr_reg.low_rate_rc_oscillator_on <= cfg_in.wdt_en || cfg_in.fail_safe_clock_monitor_en;
      end
      pwr_reg.reg_standby <= (state_reg == psm_pkg::st_sleep) && !regulator_standby_control_reg;
      pwr_reg.lp_regulator <= (state_reg == psm_pkg::st_sleep) && low_power_regulator_enable_reg;
    end
  end

  // source only switches while running, so sleep resumes on the entry source
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      active_osc_reg <= `PSM_OSC_RST;
    end else if (state_reg == psm_pkg::st_run) begin
      active_osc_reg <= new_oscillator_select_reg;
    end
  end

  // ****************************************
  // peripheral gating
  // ****************************************
  // new disable pattern applied at the next instruction cycle boundary
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      module_disable_eff_reg <= '0;
    end else if (cpu_clk_en_reg) begin
      module_disable_eff_reg <= module_disable_reg;
    end
  end

  for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_periph
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        periph_on_reg[i] <= 1'b0;
      end else begin
        periph_on_reg[i] <= PERIPH_PRESENT[i] && !module_disable_eff_reg[i] &&
                            (state_reg != psm_pkg::st_sleep) &&
                            !((state_reg == psm_pkg::st_idle) && stop_in_idle_bit_reg[i]);
      end
    end
  end

  // ****************************************
  // read back
  // ****************************************
  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      `PSM_OFF_OSC_CTL: rd_mux[`PSM_NOSC_HI:`PSM_NOSC_LO] = new_oscillator_select_reg;
      `PSM_OFF_RST_CTL: begin
        rd_mux[`PSM_REG_STBY_BIT] = regulator_standby_control_reg;
        rd_mux[`PSM_LP_REG_BIT] = low_power_regulator_enable_reg;
      end
      `PSM_OFF_CLK_DIV: begin
        rd_mux[`PSM_ROI_BIT] = return_on_interrupt_reg;
        rd_mux[`PSM_RATIO_HI:`PSM_RATIO_LO] = doze_ratio_reg;
        rd_mux[`PSM_DOZE_EN_BIT] = cpu_slowdown_enable_reg;
      end
      `PSM_OFF_MOD_DIS: rd_mux[NUM_PERIPH-1:0] = module_disable_reg;
      `PSM_OFF_STOP_IDLE: rd_mux[NUM_PERIPH-1:0] = stop_in_idle_bit_reg;
      `PSM_OFF_STATUS: begin
        rd_mux[`PSM_ST_SLEEP_BIT] = (state_reg == psm_pkg::st_sleep);
        rd_mux[`PSM_ST_IDLE_BIT] = (state_reg == psm_pkg::st_idle);
        rd_mux[`PSM_ST_DOZE_BIT] = cpu_slowdown_enable_reg;
        rd_mux[`PSM_ST_OSC_LO+2:`PSM_ST_OSC_LO] = active_osc_reg;
        rd_mux[`PSM_ST_MODE_LO+1:`PSM_ST_MODE_LO] = sleep_mode_code;
      end
      default: rd_mux = '0;
    endcase
  end

  // data only in the cycle after the read strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : '0;
    end
  end

  assign reg_rdata = rdata_reg;
  assign cpu_clk_en = cpu_clk_en_reg;
  assign cpu_resume = cpu_resume_reg;
  assign resume_isr = resume_isr_reg;
  assign wdt_clear = wdt_clear_reg;
  assign pwr_out = pwr_reg;
  assign active_osc = active_osc_reg;
  assign periph_on = periph_on_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_enter;
    (state_reg == psm_pkg::st_run) && power_save_instruction_exec;
  endsequence
  sequence s_wake_start;
    $rose(state_reg == psm_pkg::st_wake);
  endsequence
  AST_ENTRY_NEEDS_INSTR: assert property (
    (state_reg == psm_pkg::st_run) && !power_save_instruction_exec |=> state_reg == psm_pkg::st_run)
    else $error("left run without power save instruction");
  AST_SLEEP_CLOCK_OFF: assert property (
    s_enter ##0 power_save_instruction_sleep |=> ##2 !pwr_out.sysclk_on && !cpu_clk_en)
    else $error("system clock still on in sleep");
  AST_IDLE_CPU_HALT: assert property (
    state_reg == psm_pkg::st_idle |=> !cpu_clk_en && pwr_out.sysclk_on)
    else $error("idle clocking wrong");
  AST_WDT_WAKE: assert property (
    (state_reg == psm_pkg::st_sleep || state_reg == psm_pkg::st_idle) && wake_in.wdt_timeout
    |=> state_reg == psm_pkg::st_wake)
    else $error("watchdog time-out did not wake");
  AST_LOW_RATE_RC_OSCILLATOR_SLEEP: assert property (
    state_reg == psm_pkg::st_sleep && cfg_in.wdt_en |=> pwr_out.low_rate_rc_oscillator_on)
    else $error("rc oscillator off in sleep with watchdog");
  AST_WDT_CLEAR: assert property (
    s_enter ##0 cfg_in.wdt_en |=> wdt_clear ##1 !wdt_clear)
    else $error("watchdog not cleared on entry");
  AST_SLEEP_PERIPH_OFF: assert property (
    state_reg == psm_pkg::st_sleep |=> periph_on == '0)
    else $error("peripheral on during sleep");
  AST_OSC_KEPT: assert property (
    state_reg == psm_pkg::st_sleep |=> $stable(active_osc))
    else $error("clock source changed across sleep");
  AST_RESUME_TIME: assert property (
    s_wake_start |-> !cpu_resume [*3] ##1 cpu_resume ##1 cpu_clk_en || cpu_slowdown_enable_reg)
    else $error("resume timing wrong");
  AST_IRQ_HELD: assert property (
    state_reg == psm_pkg::st_enter && wake_in.irq |=> ##1 state_reg == psm_pkg::st_wake)
    else $error("coincident interrupt lost");
  AST_FULL_RATE: assert property (
    state_reg == psm_pkg::st_run && !cpu_slowdown_enable_reg && !power_save_instruction_exec |=> cpu_clk_en)
    else $error("cpu slowed without slowdown enable");
endmodule

// file: testbench/psm_cpu_model.sv
// cpu core and interrupt controller stand-in facing the power-saving block
module psm_cpu_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // bench commands
  input wire logic go,
  input wire logic go_sleep,
  input wire logic irq_now,
  input wire logic [7:0] wake_dly,
  // device side
  input wire logic cpu_resume,
  output logic exec,
  output logic sleep_op,
  output wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg;
  logic armed_reg;
  logic irq_reg;

  // one instruction issue, operand picks the mode
  always_ff @(posedge core_clk) begin
    exec <= go & ~sys_rst;
    sleep_op <= go_sleep;
  end

  // pending interrupt stays up until the core restarts
  // zero delay raises it beside the instruction itself
  always_ff @(posedge core_clk) begin
    if (sys_rst || cpu_resume) begin
      armed_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (go) begin
      armed_reg <= (wake_dly != 8'h00);
      irq_reg <= (wake_dly == 8'h00);
      cnt_reg <= wake_dly;
    end else if (armed_reg) begin
      cnt_reg <= cnt_reg - 8'h01;
      if (cnt_reg == 8'h01) begin
        irq_reg <= 1'b1;
        armed_reg <= 1'b0;
      end
    end
  end

  assign irq = irq_reg | irq_now;
endmodule

// file: testbench/tb_top.sv
// self-checking bench for the power-saving mode controller
`include "psm_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // signals
  // ****************
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic go = 1'b0;
  logic go_sleep = 1'b0;
  logic irq_now = 1'b0;
  logic [7:0] wake_dly = 8'h28;
  logic exec;
  logic sleep_op;
  logic irq_w;
  logic wdt_to = 1'b0;
  psm_pkg::psm_cfg_t cfg_s = '0;
  psm_pkg::psm_wake_t wake_s;
  psm_pkg::psm_pwr_t pwr;
  logic cpu_clk_en;
  logic cpu_resume;
  logic resume_isr;
  logic wdt_clear;
  logic [2:0] active_osc;
  logic [15:0] periph_on;
  logic [15:0] q[$];
  logic rd_d = 1'b0;
  logic [2:0] osc_v;
  logic [15:0] msk;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 47;
  int g;

  assign wake_s = {irq_w, wdt_to};
  initial begin
    forever #20 core_clk = ~core_clk;
  end

  psm_power_saving_mode_control dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .power_save_instruction_exec(exec), .power_save_instruction_sleep(sleep_op), .wake_in(wake_s),
    .cfg_in(cfg_s), .cpu_clk_en(cpu_clk_en), .cpu_resume(cpu_resume), .resume_isr(resume_isr),
    .wdt_clear(wdt_clear), .pwr_out(pwr), .active_osc(active_osc), .periph_on(periph_on));

  psm_cpu_model cpu (.core_clk(core_clk), .sys_rst(sys_rst), .go(go), .go_sleep(go_sleep),
    .irq_now(irq_now), .wake_dly(wake_dly), .cpu_resume(cpu_resume), .exec(exec), .sleep_op(sleep_op),
    .irq(irq_w));

  // ****************
  // tasks
  // ****************
  task automatic end_sim;
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (e !== s) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // drive 1 ns after the edge so design updates have landed
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick();
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick();
    reg_rd <= 1'b0;
  endtask

  task automatic gap(output int n);
    n = 0;
    do begin
      tick();
      n++;
    end while (cpu_clk_en !== 1'b1 && n < 300);
  endtask

  task automatic enter(input logic s);
    go_sleep <= s;
    go <= 1'b1;
    tick();
    go <= 1'b0;
    g = 0;
    while (cpu_clk_en !== 1'b0 && g < 10) begin
      tick();
      g++;
    end
  endtask

  task automatic wait_res;
    g = 0;
    while (cpu_resume !== 1'b1 && g < 50) begin
      tick();
      g++;
    end
    chk("cpu_resume", 1, cpu_resume);
  endtask

  // ****************
  // read data and timeout watcher
  // ****************
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    rd_d <= reg_rd;
    if (rd_d)
      chk("reg_rdata", q.pop_front(), reg_rdata);
    if (cycles > 20000) begin
      errors++;
      end_sim();
    end
  end

  // ****************
  // scenarios
  // ****************
  initial begin
    repeat (2) @(posedge core_clk);
    #1;
    sys_rst <= 1'b0;
    tick();
    chk("periph_on", 16'hFFFF, periph_on);
    rd(`PSM_OFF_CLK_DIV, 16'h0000);
    tick();
    rd(`PSM_OFF_MOD_DIS, 16'h0000);
    for (int m = 0; m < 4; m++) begin
      wr(`PSM_OFF_RST_CTL, 16'(m << 8));
      rd(`PSM_OFF_STATUS, {8'h00, m[1], ~m[0], 6'h00});
    end
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000);
    // second select is refused once the configuration locks
    osc_v = 3'($random(seed));
    wr(`PSM_OFF_OSC_CTL, {5'h00, osc_v, 8'h00});
    cfg_s <= 3'b001;
    tick();
    wr(`PSM_OFF_OSC_CTL, {5'h00, ~osc_v, 8'h00});
    rd(`PSM_OFF_OSC_CTL, {5'h00, osc_v, 8'h00});
    repeat (4) tick();
    chk("active_osc", osc_v, active_osc);
    // sleep, low power standby, watchdog and monitor on
    wr(`PSM_OFF_RST_CTL, 16'h0200);
    cfg_s <= 3'b111;
    enter(1'b1);
    chk("wdt_clear", 1, wdt_clear);
    repeat (3) tick();
    chk("sysclk_on", 0, pwr.sysclk_on);
    chk("fail_safe_clock_monitor_run", 0, pwr.fail_safe_clock_monitor_run);
    chk("low_rate_rc_oscillator_on", 1, pwr.low_rate_rc_oscillator_on);
    chk("periph_on", 16'h0000, periph_on);
    chk("reg_standby", 1, pwr.reg_standby);
    chk("lp_regulator", 1, pwr.lp_regulator);
    rd(`PSM_OFF_STATUS, {8'h00, 2'b11, osc_v, 3'b001});
    wait_res();
    chk("resume_isr", 1, resume_isr);
    repeat (2) tick();
    chk("cpu_clk_en", 1, cpu_clk_en);
    chk("active_osc", osc_v, active_osc);
    // idle, watchdog off, monitor on, one peripheral stops in idle
    cfg_s <= 3'b011;
    wake_dly <= 8'hF0;
    msk = 16'h0001 << 4'($random(seed));
    wr(`PSM_OFF_STOP_IDLE, msk);
    enter(1'b0);
    chk("wdt_clear", 0, wdt_clear);
    repeat (3) tick();
    chk("sysclk_on", 1, pwr.sysclk_on);
    chk("low_rate_rc_oscillator_on", 1, pwr.low_rate_rc_oscillator_on);
    chk("periph_on", ~msk, periph_on);
    wdt_to <= 1'b1;
    tick();
    wdt_to <= 1'b0;
    wait_res();
    chk("resume_isr", 0, resume_isr);
    repeat (3) tick();
    chk("periph_on", 16'hFFFF, periph_on);
    // interrupt beside the instruction itself
    cfg_s <= 3'b101;
    wake_dly <= 8'h00;
    enter(1'b1);
    chk("wdt_clear", 1, wdt_clear);
    wait_res();
    chk("resume_isr", 1, resume_isr);
    // every slowdown ratio
    for (int r = 0; r < 8; r++) begin
      wr(`PSM_OFF_CLK_DIV, 16'(r << 12) | 16'h0800);
      repeat (3) gap(g);
      chk("cpu_clk_en gap", 16'(1 << r), 16'(g));
      chk("periph_on", 16'hFFFF, periph_on);
      chk("sysclk_on", 1, pwr.sysclk_on);
    end
    // return on interrupt set, then clear
    wr(`PSM_OFF_CLK_DIV, 16'hA800);
    irq_now <= 1'b1;
    repeat (12) tick();
    irq_now <= 1'b0;
    rd(`PSM_OFF_CLK_DIV, 16'hA000);
    gap(g);
    chk("cpu_clk_en gap", 16'h0001, 16'(g));
    wr(`PSM_OFF_CLK_DIV, 16'h2800);
    irq_now <= 1'b1;
    repeat (12) tick();
    irq_now <= 1'b0;
    rd(`PSM_OFF_CLK_DIV, 16'h2800);
    // module disable and re-enable
    wr(`PSM_OFF_CLK_DIV, 16'h0000);
    msk = 16'h0001 << 4'($random(seed));
    tick();
    wr(`PSM_OFF_MOD_DIS, msk);
    chk("periph_on", 16'hFFFF, periph_on);
    repeat (3) tick();
    chk("periph_on", ~msk, periph_on);
    rd(`PSM_OFF_MOD_DIS, msk);
    wr(`PSM_OFF_MOD_DIS, 16'h0000);
    repeat (3) tick();
    chk("periph_on", 16'hFFFF, periph_on);
    // device reset in mid-sleep brings the core back at full rate
    wake_dly <= 8'hF0;
    enter(1'b1);
    repeat (3) tick();
    chk("sysclk_on", 0, pwr.sysclk_on);
    sys_rst <= 1'b1;
    repeat (2) tick();
    sys_rst <= 1'b0;
    tick();
    chk("cpu_clk_en", 1, cpu_clk_en);
    chk("sysclk_on", 1, pwr.sysclk_on);
    chk("periph_on", 16'hFFFF, periph_on);
    chk("active_osc", `PSM_OSC_RST, active_osc);
    tick();
    end_sim();
  end
endmodule
